// File: rtl/light_prox_threshold_irq.sv
/*
 * ambient / proximity threshold, persistence and interrupt logic behind a
 * two-wire serial slave with command-coded 16-bit registers.
 * assumes converter samples on the core clock; scl and sda come from pins.
 */
// Contract
// - registers reset to defaults, no init needed
// - ambient thresholds built from two bytes
// - ambient outside window raises enabled interrupt
// - integration field picks 50 to 800 ms
// - each range option halves sensitivity, combinable
// - ambient persistence 1,2,4,8 consecutive periods
// - proximity compared against high and low thresholds
// - proximity persistence 1 to 4 periods
// - force mode: no result without trigger
// - every command register reads back
// - ambient result low/high byte in one word
// - crosstalk offset subtracted from raw proximity
// - shared interrupt pin driven low
// - registers stay accessible while interrupt asserted
// - proximity select: close, away, both, none
// - any flag rising pulls pin low
// - flag read clears flags after data returned
// - flag byte bit layout
// - close above high, away below low
`timescale 1ns/1ps
`default_nettype none

module light_prox_threshold_irq #(
    parameter logic [6:0]  slaveAddr        = light_prox_pkg::SLAVE_ADDR,
    parameter int unsigned ambBaseCycles    = light_prox_pkg::AMB_BASE_CYCLES,
    parameter int unsigned proxPeriodCycles = light_prox_pkg::PROX_PERIOD_CYCLES
) (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // serial bus pins
    input  wire logic        scl,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOeN,
    // interrupt pin
    output logic             intN,
    // converter samples
    input  wire logic [15:0] ambientRaw,
    input  wire logic [15:0] proximityRaw,
    input  wire logic        sunlightActive
);

    light_prox_pkg::state_t s;
    light_prox_pkg::state_t n;

    logic [15:0] words [16];
    logic [15:0] memRd;
    logic        sclNow;
    logic        sdaNow;
    logic        sclRise;
    logic        sclFall;
    logic        startSeen;
    logic        stopSeen;
    logic [15:0] rdWord;
    logic        writable;
    logic [7:0]  txByte;
    logic        txSel;
    logic [7:0]  setMask;
    logic [7:0]  clearMask;
    logic [2:0]  itCode;
    logic [2:0]  itShift;
    logic [31:0] ambPeriod;
    logic [1:0]  rangeShift;
    logic [15:0] ambScaled;
    logic [3:0]  ambPersN;
    logic [2:0]  proxPersN;
    logic [15:0] proxCorr;
    logic        ambDone;
    logic        proxDone;
    logic        proxRun;
    logic        ambOut;
    logic [3:0]  ambNextCnt;
    logic [2:0]  closeNextCnt;
    logic [2:0]  awayNextCnt;

    cmd_reg_file #(
        .DEPTH (16),
        .AW    (4)
    ) u_regs (
        .clock  (clock),
        .rst    (rst),
        .ce     (ce),
        .wr     (s.wr),
        .rdAddr (s.cmd[3:0]),
        .rdData (memRd),
        .words  (words)
    );

    assign sclNow    = s.sclSync[1];
    assign sdaNow    = s.sdaSync[1];
    assign sclRise   = sclNow && !s.sclPrev;
    assign sclFall   = !sclNow && s.sclPrev;
    assign startSeen = sclNow && s.sclPrev && s.sdaPrev && !sdaNow;
    assign stopSeen  = sclNow && s.sclPrev && !s.sdaPrev && sdaNow;

    always_comb begin
        n         = s;
        setMask   = '0;
        clearMask = '0;
        n.wr.en   = 1'b0;
        n.sclSync = {s.sclSync[0], scl};
        n.sdaSync = {s.sdaSync[0], sdaIn};
        n.sclPrev = sclNow;
        n.sdaPrev = sdaNow;

        unique case (s.cmd)
            light_prox_pkg::CMD_PROX_RESULT: rdWord = s.proxResult;
            light_prox_pkg::CMD_AMB_RESULT:  rdWord = s.ambResult;
            light_prox_pkg::CMD_FLAGS:       rdWord = {s.flags, 8'h00};
            default:                         rdWord = (s.cmd[7:4] == 4'h0) ? memRd : 16'h0000;
        endcase
        txSel  = (s.bus == light_prox_pkg::BUS_RACK) ? !s.byteSel : 1'b0;
        txByte = txSel ? rdWord[15:8] : rdWord[7:0];
        writable = (s.cmd[7:4] == 4'h0)
                && (s.cmd != light_prox_pkg::CMD_PROX_RESULT)
                && (s.cmd != light_prox_pkg::CMD_AMB_RESULT)
                && (s.cmd != light_prox_pkg::CMD_FLAGS);

        if (startSeen) begin
            n.bus     = light_prox_pkg::BUS_ADDR;
            n.bitCnt  = 4'h0;
            n.byteSel = 1'b0;
            n.sdaOeN  = 1'b1;
        end else if (stopSeen) begin
            n.bus    = light_prox_pkg::BUS_IDLE;
            n.sdaOeN = 1'b1;
        end else begin
            unique case (s.bus)
                light_prox_pkg::BUS_IDLE: begin
                    n.sdaOeN = 1'b1;
                end
                light_prox_pkg::BUS_ADDR,
                light_prox_pkg::BUS_CMD,
                light_prox_pkg::BUS_WDATA: begin
                    if (sclRise) begin
                        n.shift  = {s.shift[6:0], sdaNow};
                        n.bitCnt = s.bitCnt + 4'h1;
                    end else if (sclFall && s.bitCnt == 4'h8) begin
                        n.bitCnt = 4'h0;
                        if (s.bus == light_prox_pkg::BUS_ADDR) begin
                            if (s.shift[7:1] == slaveAddr) begin
                                n.readDir = s.shift[0];
                                n.sdaOeN  = 1'b0;
                                n.bus     = light_prox_pkg::BUS_ADDR_ACK;
                            end else begin
                                n.bus = light_prox_pkg::BUS_IDLE;
                            end
                        end else if (s.bus == light_prox_pkg::BUS_CMD) begin
                            n.cmd     = s.shift;
                            n.byteSel = 1'b0;
                            n.sdaOeN  = 1'b0;
                            n.bus     = light_prox_pkg::BUS_CMD_ACK;
                        end else begin
                            n.wr.en   = writable;
                            n.wr.addr = s.cmd[3:0];
                            n.wr.data = {s.shift, s.shift};
                            n.wr.be   = s.byteSel ? 2'b10 : 2'b01;
                            if (writable && !s.byteSel
                                    && s.cmd == light_prox_pkg::CMD_PROX_CONF3
                                    && s.shift[light_prox_pkg::PROX_TRIG_BIT]) begin
                                n.trigPending = 1'b1;
                            end
                            n.sdaOeN = 1'b0;
                            n.bus    = light_prox_pkg::BUS_WDATA_ACK;
                        end
                    end
                end
                light_prox_pkg::BUS_ADDR_ACK: begin
                    if (sclFall) begin
                        if (s.readDir) begin
                            n.sdaOeN    = txByte[7];
                            n.shift     = {txByte[6:0], 1'b0};
                            n.byteSel   = 1'b0;
                            n.bus       = light_prox_pkg::BUS_RDATA;
                        end else begin
                            n.sdaOeN = 1'b1;
                            n.bus    = light_prox_pkg::BUS_CMD;
                        end
                    end
                end
                light_prox_pkg::BUS_CMD_ACK: begin
                    if (sclFall) begin
                        n.sdaOeN = 1'b1;
                        n.bus    = light_prox_pkg::BUS_WDATA;
                    end
                end
                light_prox_pkg::BUS_WDATA_ACK: begin
                    if (sclFall) begin
                        n.sdaOeN  = 1'b1;
                        n.byteSel = !s.byteSel;
                        n.bus     = light_prox_pkg::BUS_WDATA;
                    end
                end
                light_prox_pkg::BUS_RDATA: begin
                    if (sclRise) begin
                        n.bitCnt = s.bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (s.bitCnt == 4'h8) begin
                            n.sdaOeN = 1'b1;
                            n.bitCnt = 4'h0;
                            n.bus    = light_prox_pkg::BUS_RACK;
                            if (s.byteSel && s.cmd == light_prox_pkg::CMD_FLAGS) begin
                                clearMask = s.readFlags;
                            end
                        end else begin
                            n.sdaOeN = s.shift[7];
                            n.shift  = {s.shift[6:0], 1'b0};
                        end
                    end
                end
                light_prox_pkg::BUS_RACK: begin
                    if (sclRise) begin
                        n.masterAck = !sdaNow;
                    end else if (sclFall) begin
                        if (s.masterAck) begin
                            n.sdaOeN  = txByte[7];
                            n.shift   = {txByte[6:0], 1'b0};
                            n.readFlags = txByte;
                            n.byteSel = !s.byteSel;
                            n.bus     = light_prox_pkg::BUS_RDATA;
                        end else begin
                            n.bus = light_prox_pkg::BUS_IDLE;
                        end
                    end
                end
            endcase
        end

        itCode    = words[light_prox_pkg::CMD_AMB_CONF[3:0]][light_prox_pkg::AMB_IT_LSB +: 3];
        itShift   = (itCode > light_prox_pkg::AMB_IT_MAX_SHIFT) ?
                    light_prox_pkg::AMB_IT_MAX_SHIFT : itCode;
        ambPeriod = 32'(ambBaseCycles) << itShift;
        ambDone   = (s.ambTimer >= ambPeriod - 32'h1);
        n.ambTimer = ambDone ? 32'h0 : s.ambTimer + 32'h1;

        rangeShift = 2'(words[light_prox_pkg::CMD_AMB_CONF[3:0]][light_prox_pkg::AMB_RANGE_A_BIT])
                   + 2'(words[light_prox_pkg::CMD_AMB_CONF[3:0]][light_prox_pkg::AMB_RANGE_B_BIT]);
        ambScaled  = ambientRaw >> rangeShift;
        ambPersN   = 4'h1 << words[light_prox_pkg::CMD_AMB_CONF[3:0]][light_prox_pkg::AMB_PERS_LSB +: 2];

        ambOut     = 1'b0;
        ambNextCnt = s.ambCount;
        if (ambDone) begin
            n.ambResult = ambScaled;
            ambOut = (ambScaled > words[light_prox_pkg::CMD_AMB_HIGH[3:0]])
                  || (ambScaled < words[light_prox_pkg::CMD_AMB_LOW[3:0]]);
            ambNextCnt = !ambOut ? 4'h0 :
                         (s.ambCount == 4'h8) ? 4'h8 : s.ambCount + 4'h1;
            n.ambCount = ambNextCnt;
            if (ambOut && ambNextCnt >= ambPersN
                    && words[light_prox_pkg::CMD_AMB_CONF[3:0]][light_prox_pkg::AMB_IRQ_EN_BIT]) begin
                setMask[light_prox_pkg::FLAG_AMB_HIGH] =
                    ambScaled > words[light_prox_pkg::CMD_AMB_HIGH[3:0]];
                setMask[light_prox_pkg::FLAG_AMB_LOW] =
                    ambScaled < words[light_prox_pkg::CMD_AMB_LOW[3:0]];
            end
        end

        proxRun  = !words[light_prox_pkg::CMD_PROX_CONF3[3:0]][light_prox_pkg::PROX_FORCE_BIT]
                || s.trigPending;
        proxDone = proxRun && (s.proxTimer >= 32'(proxPeriodCycles) - 32'h1);
        n.proxTimer = (proxDone || !proxRun) ? 32'h0 : s.proxTimer + 32'h1;

        proxCorr = (proximityRaw > words[light_prox_pkg::CMD_PROX_OFFSET[3:0]]) ?
                   proximityRaw - words[light_prox_pkg::CMD_PROX_OFFSET[3:0]] : 16'h0000;
        proxPersN = 3'(words[light_prox_pkg::CMD_PROX_CONF[3:0]][light_prox_pkg::PROX_PERS_LSB +: 2])
                  + 3'h1;
        closeNextCnt = s.closeCount;
        awayNextCnt  = s.awayCount;
        if (proxDone) begin
            n.proxResult  = proxCorr;
            n.trigPending = 1'b0;
            closeNextCnt = !(proxCorr > words[light_prox_pkg::CMD_PROX_HIGH[3:0]]) ? 3'h0 :
                           (s.closeCount == 3'h4) ? 3'h4 : s.closeCount + 3'h1;
            awayNextCnt  = !(proxCorr < words[light_prox_pkg::CMD_PROX_LOW[3:0]]) ? 3'h0 :
                           (s.awayCount == 3'h4) ? 3'h4 : s.awayCount + 3'h1;
            n.closeCount = closeNextCnt;
            n.awayCount  = awayNextCnt;
            if (closeNextCnt != 3'h0 && closeNextCnt >= proxPersN
                    && words[light_prox_pkg::CMD_PROX_CONF[3:0]][light_prox_pkg::PROX_SEL_LSB]) begin
                setMask[light_prox_pkg::FLAG_CLOSE] = 1'b1;
            end
            if (awayNextCnt != 3'h0 && awayNextCnt >= proxPersN
                    && words[light_prox_pkg::CMD_PROX_CONF[3:0]][light_prox_pkg::PROX_SEL_LSB + 1]) begin
                setMask[light_prox_pkg::FLAG_AWAY] = 1'b1;
            end
        end

        n.sunPrev = sunlightActive;
        if (sunlightActive && !s.sunPrev) begin
            setMask[light_prox_pkg::FLAG_SUN] = 1'b1;
        end

        n.flags = (s.flags & ~clearMask) | setMask;
        n.intN   = ~(|n.flags);
        n.sdaOut = 1'b0;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s             <= '0;
            s.sclSync     <= 2'b11;
            s.sdaSync     <= 2'b11;
            s.sclPrev     <= 1'b1;
            s.sdaPrev     <= 1'b1;
            s.bus         <= light_prox_pkg::BUS_IDLE;
            s.sdaOeN      <= 1'b1;
            s.flags       <= light_prox_pkg::FLAGS_RESET;
            s.intN        <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    assign sdaOut = s.sdaOut;
    assign sdaOeN = s.sdaOeN;
    assign intN   = s.intN;

endmodule : light_prox_threshold_irq

`default_nettype wire

// File: rtl/light_prox_pkg.sv
/*
 * shared constants and types of the light / proximity threshold block:
 * command codes, field positions, reset values, timing counts, state types.
 * assumes a 200 MHz core clock.
 */
package light_prox_pkg;

    // clock and timing
    localparam int unsigned CLOCK_MHZ          = 200;
    localparam int unsigned CLOCK_KHZ          = CLOCK_MHZ * 1000;
    localparam int unsigned AMB_BASE_MS        = 50;
    localparam int unsigned AMB_BASE_CYCLES    = AMB_BASE_MS * CLOCK_KHZ;
    localparam int unsigned PROX_PERIOD_US     = 5000;
    localparam int unsigned PROX_PERIOD_CYCLES = PROX_PERIOD_US * CLOCK_MHZ;
    localparam logic [2:0]  AMB_IT_MAX_SHIFT   = 3'h4;

    // bus slave address (7-bit)
    localparam logic [6:0] SLAVE_ADDR = 7'h60;

    // command codes
    localparam logic [7:0] CMD_AMB_CONF    = 8'h00;
    localparam logic [7:0] CMD_AMB_HIGH    = 8'h01;
    localparam logic [7:0] CMD_AMB_LOW     = 8'h02;
    localparam logic [7:0] CMD_PROX_CONF   = 8'h03;
    localparam logic [7:0] CMD_PROX_CONF3  = 8'h04;
    localparam logic [7:0] CMD_PROX_OFFSET = 8'h05;
    localparam logic [7:0] CMD_PROX_LOW    = 8'h06;
    localparam logic [7:0] CMD_PROX_HIGH   = 8'h07;
    localparam logic [7:0] CMD_PROX_RESULT = 8'h08;
    localparam logic [7:0] CMD_AMB_RESULT  = 8'h0b;
    localparam logic [7:0] CMD_FLAGS       = 8'h0d;

    // field positions inside the 16-bit command words
    localparam int unsigned AMB_IT_LSB      = 5;
    localparam int unsigned AMB_PERS_LSB    = 2;
    localparam int unsigned AMB_IRQ_EN_BIT  = 1;
    localparam int unsigned AMB_RANGE_A_BIT = 8;
    localparam int unsigned AMB_RANGE_B_BIT = 9;
    localparam int unsigned PROX_PERS_LSB   = 4;
    localparam int unsigned PROX_SEL_LSB    = 8;
    localparam int unsigned PROX_MECH_BIT   = 11;
    localparam int unsigned PROX_FORCE_BIT  = 3;
    localparam int unsigned PROX_TRIG_BIT   = 2;

    // flag byte layout
    localparam int unsigned FLAG_AMB_LOW  = 5;
    localparam int unsigned FLAG_AMB_HIGH = 4;
    localparam int unsigned FLAG_SUN      = 2;
    localparam int unsigned FLAG_CLOSE    = 1;
    localparam int unsigned FLAG_AWAY     = 0;

    // reset values
    localparam logic [15:0] REG_RESET   = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;

    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_CMD,
        BUS_CMD_ACK,
        BUS_WDATA,
        BUS_WDATA_ACK,
        BUS_RDATA,
        BUS_RACK
    } busState_t;

    typedef struct packed {
        logic        en;
        logic [3:0]  addr;
        logic [15:0] data;
        logic [1:0]  be;
    } memWrite_t;

    typedef struct packed {
        logic [1:0]  sclSync;
        logic [1:0]  sdaSync;
        logic        sclPrev;
        logic        sdaPrev;
        busState_t   bus;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic [7:0]  cmd;
        logic        readDir;
        logic        byteSel;
        logic        masterAck;
        logic [7:0]  readFlags;
        logic        sdaOeN;
        logic        sdaOut;
        memWrite_t   wr;
        logic [31:0] ambTimer;
        logic [31:0] proxTimer;
        logic [15:0] ambResult;
        logic [15:0] proxResult;
        logic [3:0]  ambCount;
        logic [2:0]  closeCount;
        logic [2:0]  awayCount;
        logic        trigPending;
        logic        sunPrev;
        logic [7:0]  flags;
        logic        intN;
    } state_t;

endpackage : light_prox_pkg

// File: rtl/cmd_reg_file.sv
/*
 * command register storage: byte-writable words, registered read port,
 * and every word visible in parallel for the sensing logic.
 * assumes writes arrive on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cmd_reg_file #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic                    ce,
    // write port
    input  wire light_prox_pkg::memWrite_t wr,
    // read port
    input  wire logic [AW-1:0]           rdAddr,
    output logic      [15:0]             rdData,
    // parallel view
    output logic      [15:0]             words [DEPTH]
);

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    words[i] <= light_prox_pkg::REG_RESET;
                end else if (ce && wr.en && wr.addr == AW'(i)) begin
                    if (wr.be[0]) begin
                        words[i][7:0] <= wr.data[7:0];
                    end
                    if (wr.be[1]) begin
                        words[i][15:8] <= wr.data[15:8];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData <= light_prox_pkg::REG_RESET;
        end else if (ce) begin
            rdData <= words[rdAddr];
        end
    end

endmodule : cmd_reg_file

`default_nettype wire

// File: verif/light_prox_threshold_irq_assertions.sv
/* checker for the threshold block: reset idle, interrupt pin, sda drive timing.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module light_prox_threshold_irq_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // pins
    input wire logic scl,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    input wire logic intN,
    input wire logic sunlightActive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_reset_idle: assert property (disable iff (1'b0) rst ##1 rst |-> intN && sdaOeN)
        else $error("outputs not idle in reset");
    a_release_idle: assert property ($fell(rst) |-> (intN && sdaOeN) [*3])
        else $error("outputs not idle after reset");
    a_sun_irq: assert property (ce && $rose(sunlightActive) |-> ##[1:3] !intN)
        else $error("sunlight edge did not pull interrupt low");
    a_int_sticky: assert property (!intN && scl |=> !intN)
        else $error("interrupt released while bus clock high");
    a_int_rise: assert property ($rose(intN) |-> !scl && !$past(scl) && !$past(scl, 2))
        else $error("interrupt released without a bus clock fall");
    a_sda_scl_low: assert property (!$stable(sdaOeN) |-> !scl)
        else $error("sda drive changed while bus clock high");
    a_drive_hold: assert property ($fell(sdaOeN) |-> !sdaOeN [*8])
        else $error("sda drive shorter than a bit");
    a_open_drain: assert property (sdaOut == 1'b0)
        else $error("sda output not low");
    c_sun: cover property ($rose(sunlightActive) ##2 !intN);
    c_clear: cover property ($rose(intN));
    c_ack: cover property ($fell(sdaOeN));
endmodule : light_prox_threshold_irq_checker
bind light_prox_threshold_irq light_prox_threshold_irq_checker i_light_prox_threshold_irq_checker (
    .clock(clock), .rst(rst), .ce(ce), .scl(scl), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .intN(intN), .sunlightActive(sunlightActive));
`default_nettype wire

// File: verif/bus_host.sv
/* host model: two-wire bus master with word write and word read.
   assumes the bench resolves the open-drain wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module bus_host (
    // clock
    input  wire logic clock,
    // bus wire
    input  wire logic sda,
    output logic      scl,
    output logic      sdaDrvN
);
    logic       ack;
    logic [7:0] rb;
    initial begin
        scl = 1'b1;
        sdaDrvN = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tk
    // data set mid-low, sampled late in high
    task automatic bitx(input logic b, output logic r);
        tk(6);
        sdaDrvN = b;
        tk(10);
        scl = 1'b1;
        tk(15);
        r = sda;
        tk(1);
        scl = 1'b0;
    endtask : bitx
    task automatic start;
        sdaDrvN = 1'b1;
        tk(8);
        scl = 1'b1;
        tk(8);
        sdaDrvN = 1'b0;
        tk(8);
        scl = 1'b0;
    endtask : start
    task automatic stop;
        tk(6);
        sdaDrvN = 1'b0;
        tk(10);
        scl = 1'b1;
        tk(8);
        sdaDrvN = 1'b1;
        tk(8);
    endtask : stop
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(last, ack);
    endtask : xbyte
    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        start;
        xbyte({light_prox_pkg::SLAVE_ADDR, 1'b0}, 1'b1, rb);
        xbyte(c, 1'b1, rb);
        xbyte(v[7:0], 1'b1, rb);
        xbyte(v[15:8], 1'b1, rb);
        stop;
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        start;
        xbyte({light_prox_pkg::SLAVE_ADDR, 1'b0}, 1'b1, rb);
        xbyte(c, 1'b1, rb);
        start;
        xbyte({light_prox_pkg::SLAVE_ADDR, 1'b1}, 1'b1, rb);
        xbyte(8'hff, 1'b0, v[7:0]);
        xbyte(8'hff, 1'b1, v[15:8]);
        stop;
    endtask : rd
endmodule : bus_host
`default_nettype wire

// File: verif/test_light_prox_threshold_irq.sv
/* bench for the threshold block: registers, sunlight, proximity, force mode,
   ambient timing. assumes a pull-up on sda and the host model on the bus. */
`timescale 1ns/1ps
`default_nettype none
module test_light_prox_threshold_irq;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        ceOn = 1'b1;
    logic        scl, sdaDrvN, sda, sdaOut, sdaOeN, intN, sunlightActive;
    logic [15:0] ambientRaw, proximityRaw;
    logic [7:0]  cm [5] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h07};
    logic [15:0] cv [5] = '{16'h1000, 16'h0100, 16'h0010, 16'h0080, 16'h0100};
    int          errorCnt, totalChecks, cyc, t0, n;
    assign sda = sdaDrvN & (sdaOeN | sdaOut);
    always #2.5 clock = ~clock;
    bus_host i_bus_host (.clock(clock), .sda(sda), .scl(scl), .sdaDrvN(sdaDrvN));
    light_prox_threshold_irq #(.ambBaseCycles(20), .proxPeriodCycles(16))
    i_light_prox_threshold_irq (.clock(clock), .rst(rst), .ce(ceOn), .scl(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .intN(intN),
        .ambientRaw(ambientRaw), .proximityRaw(proximityRaw),
        .sunlightActive(sunlightActive));
    task automatic giveVerdict;
        $display("checks=%0d errors=%0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : giveVerdict
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            errorCnt++;
            giveVerdict;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] v;
        i_bus_host.rd(c, v);
        chk(v, e);
    endtask : rdc
    task automatic waitLow;
        n = 0;
        while (intN !== 1'b0 && n < 2000) begin
            i_bus_host.tk(1);
            n++;
        end
    endtask : waitLow
    task automatic sRegs;
        chk({15'h0, intN}, 16'h0001);
        for (int c = 0; c < 8; c++) rdc(c[7:0], 16'h0000);
        for (int i = 0; i < 5; i++) i_bus_host.wr(cm[i], cv[i]);
        for (int i = 0; i < 5; i++) rdc(cm[i], cv[i]);
    endtask : sRegs
    task automatic sSun;
        sunlightActive = 1'b1;
        i_bus_host.tk(3);
        chk({15'h0, intN}, 16'h0000);
        rdc(8'h0d, 16'h0400);
        chk({15'h0, intN}, 16'h0001);
        rdc(8'h0d, 16'h0000);
        sunlightActive = 1'b0;
    endtask : sSun
    task automatic sHold;
        i_bus_host.tk(2);
        ceOn = 1'b0;
        sunlightActive = 1'b1;
        i_bus_host.tk(6);
        chk({15'h0, intN}, 16'h0001);
        ceOn = 1'b1;
        i_bus_host.tk(3);
        chk({15'h0, intN}, 16'h0000);
        rdc(8'h0d, 16'h0400);
        sunlightActive = 1'b0;
    endtask : sHold
    task automatic sProx;
        proximityRaw = 16'h00c0;
        i_bus_host.wr(8'h03, 16'h0920);
        rdc(8'h08, 16'h00b0);
        rdc(8'h0d, 16'h0000);
        proximityRaw = 16'h0150;
        waitLow;
        proximityRaw = 16'h00c0;
        chk({15'h0, n > 32 && n <= 51}, 16'h0001);
        rdc(8'h0d, 16'h0200);
        proximityRaw = 16'h0050;
        i_bus_host.tk(60);
        chk({15'h0, intN}, 16'h0001);
        i_bus_host.wr(8'h03, 16'h0a20);
        waitLow;
        proximityRaw = 16'h00c0;
        rdc(8'h0d, 16'h0100);
    endtask : sProx
    task automatic sForce;
        i_bus_host.wr(8'h04, 16'h0008);
        proximityRaw = 16'h0090;
        rdc(8'h08, 16'h00b0);
        i_bus_host.wr(8'h04, 16'h000c);
        i_bus_host.tk(20);
        rdc(8'h08, 16'h0080);
        rdc(8'h04, 16'h000c);
    endtask : sForce
    task automatic sAmb;
        ambientRaw = 16'h2000;
        i_bus_host.wr(8'h00, 16'h03e2);
        ambientRaw = 16'h8000;
        waitLow;
        t0 = cyc;
        ambientRaw = 16'h2000;
        rdc(8'h0b, 16'h0800);
        rdc(8'h0d, 16'h1000);
        while ((cyc - t0) % 320 != 10) i_bus_host.tk(1);
        ambientRaw = 16'h0100;
        waitLow;
        chk(16'((cyc - t0) % 320), 16'h0000);
        rdc(8'h0d, 16'h2000);
    endtask : sAmb
    initial begin
        ambientRaw = 16'h0000;
        proximityRaw = 16'h0000;
        sunlightActive = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        i_bus_host.tk(4);
        sRegs;
        sSun;
        sHold;
        sProx;
        sForce;
        sAmb;
        giveVerdict;
    end
endmodule : test_light_prox_threshold_irq
`default_nettype wire
